// File: verilog/bsl_regs.vh
// Constants for the branch, skip and load execution core.
// Assumes an APB master on the register side, one 25 MHz clock.
`ifndef BSL_REGS_VH
`define BSL_REGS_VH

// APB register byte offsets
`define BSL_OFS_CTRL   8'h00
`define BSL_OFS_PC     8'h04
`define BSL_OFS_FLAGS  8'h08
`define BSL_OFS_RSEL   8'h0C
`define BSL_OFS_RDATA  8'h10
`define BSL_OFS_STATE  8'h14

// Control fields and reset values
`define BSL_CTRL_RUN   0
`define BSL_RUN_RST    1'b0
`define BSL_PC_RST     16'h0000
`define BSL_FLAGS_RST  8'h00

// Status flag bit positions
`define BSL_FLAG_C     0
`define BSL_FLAG_Z     1
`define BSL_FLAG_N     2
`define BSL_FLAG_V     3
`define BSL_FLAG_S     4
`define BSL_FLAG_H     5
`define BSL_FLAG_T     6
`define BSL_FLAG_I     7

// Execution cycle counts
`define BSL_CYC_TAKEN  2'h1
`define BSL_CYC_SKIP1  2'h1
`define BSL_CYC_SKIP2  2'h2
`define BSL_CYC_LOAD   2'h2

`endif

// File: verilog/bsl_flag_eval.v
// Compare-immediate flag generation and branch condition select.
// Purely combinational; the core registers cmp_flags on a compare and uses flag_cond unregistered.
`timescale 1ns/1ns
`include "bsl_regs.vh"

module bsl_flag_eval (
	flags_in,
	reg_val,
	imm_val,
	flag_sel,
	cmp_flags,
	flag_cond
);
	input  wire [7:0] flags_in;
	input  wire [7:0] reg_val;
	input  wire [7:0] imm_val;
	input  wire [2:0] flag_sel;
	output reg  [7:0] cmp_flags;
	output reg        flag_cond;

	wire [7:0] diff;

	assign diff = reg_val - imm_val;

	//==========================================================
	// Compare flags, difference discarded
	always @* begin
		cmp_flags = flags_in;
		cmp_flags[`BSL_FLAG_H] = (~reg_val[3] & imm_val[3]) |
			(imm_val[3] & diff[3]) | (diff[3] & ~reg_val[3]);
		cmp_flags[`BSL_FLAG_V] = (reg_val[7] & ~imm_val[7] & ~diff[7]) |
			(~reg_val[7] & imm_val[7] & diff[7]);
		cmp_flags[`BSL_FLAG_N] = diff[7];
		cmp_flags[`BSL_FLAG_Z] = (diff == 8'h00);
		cmp_flags[`BSL_FLAG_C] = (~reg_val[7] & imm_val[7]) |
			(imm_val[7] & diff[7]) | (diff[7] & ~reg_val[7]);
	end

	//==========================================================
	// Selected flag; signed slot uses N xor V
	always @* begin
		if (flag_sel == `BSL_FLAG_S) begin
			flag_cond = flags_in[`BSL_FLAG_N] ^ flags_in[`BSL_FLAG_V];
		end else begin
			flag_cond = flags_in[flag_sel];
		end
	end

endmodule

// File: verilog/bsl_core.v
// Execution core for compare, skip, branch, move and load instructions.
// Program memory returns words at pc and pc+1 in the same cycle; data
// memory returns read data in the same cycle that data_rd is high.
`timescale 1ns/1ns
`include "bsl_regs.vh"

module bsl_core #(
	parameter PC_W = 16
) (
	sys_clk,
	rst_n,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	prog_addr,
	prog_data,
	prog_next,
	io_bits,
	data_addr,
	data_rd,
	data_rdata
);
	input  wire            sys_clk;
	input  wire            rst_n;
	input  wire            psel;
	input  wire            penable;
	input  wire            pwrite;
	input  wire [7:0]      paddr;
	input  wire [31:0]     pwdata;
	output reg  [31:0]     prdata;
	output wire            pready;
	output wire            pslverr;
	output wire [PC_W-1:0] prog_addr;
	input  wire [15:0]     prog_data;
	input  wire [15:0]     prog_next;
	input  wire [255:0]    io_bits;
	output reg  [15:0]     data_addr;
	output reg             data_rd;
	input  wire [7:0]      data_rdata;

	localparam ST_EXEC = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_LOAD = 2'h2;

	localparam LD_PLAIN = 2'h0;
	localparam LD_INC   = 2'h1;
	localparam LD_DEC   = 2'h2;

	localparam PTR_X = 2'h1;
	localparam PTR_Y = 2'h2;
	localparam PTR_Z = 2'h3;

	reg  [7:0]      regs [0:31];
	reg  [PC_W-1:0] pc;
	reg  [7:0]      flags;
	reg  [1:0]      state;
	reg  [1:0]      wait_left;
	reg  [4:0]      load_dst;
	reg             run;
	reg  [4:0]      reg_sel;

	wire [15:0] instr;
	wire [4:0]  fld_d;
	wire [4:0]  fld_r;
	wire [4:0]  fld_dh;
	wire [7:0]  fld_k;
	wire [2:0]  fld_b;
	wire [4:0]  fld_io;
	wire [5:0]  fld_q;
	wire [7:0]  cmp_flags;
	wire        flag_cond;
	wire        skip_two;
	wire [1:0]  skip_cyc;
	wire        apb_wr;
	wire        apb_setup;
	wire        core_edit;
	wire [PC_W-1:0] br_target;

	reg         ld_hit;
	reg  [1:0]  ld_ptr;
	reg  [1:0]  ld_mode;
	reg         ld_direct;
	reg  [5:0]  ld_disp;
	reg  [4:0]  ptr_lo;
	reg  [4:0]  ptr_hi;
	reg  [15:0] ptr_val;
	reg  [15:0] ld_addr;
	reg  [15:0] ptr_new;
	reg         addr_ok;
	reg  [31:0] next_prdata;

	integer i;

	//==========================================================
	// Word length of the instruction being skipped
	function is_two_word;
		input [15:0] w;
		begin
			is_two_word = ((w & 16'hFC0F) == 16'h9000) ||
				((w & 16'hFE0C) == 16'h940C);
		end
	endfunction

	//==========================================================
	// Instruction fields
	assign instr  = prog_data;
	assign fld_d  = instr[8:4];
	assign fld_r  = {instr[9], instr[3:0]};
	assign fld_dh = {1'b1, instr[7:4]};
	assign fld_k  = {instr[11:8], instr[3:0]};
	assign fld_b  = instr[2:0];
	assign fld_io = instr[7:3];
	assign fld_q  = {instr[13], instr[11:10], instr[2:0]};

	assign prog_addr = pc;
	assign br_target = pc + {{(PC_W-7){instr[9]}}, instr[9:3]} +
		{{(PC_W-1){1'b0}}, 1'b1};

	assign skip_two = is_two_word(prog_next);
	assign skip_cyc = skip_two ? `BSL_CYC_SKIP2 : `BSL_CYC_SKIP1;

	bsl_flag_eval u_flag_eval (
		.flags_in  (flags),
		.reg_val   (regs[fld_dh]),
		.imm_val   (fld_k),
		.flag_sel  (fld_b),
		.cmp_flags (cmp_flags),
		.flag_cond (flag_cond)
	);

	//==========================================================
	// Load decode and pointer arithmetic
	always @* begin
		ld_hit    = 1'b0;
		ld_ptr    = PTR_Z;
		ld_mode   = LD_PLAIN;
		ld_direct = 1'b0;
		ld_disp   = 6'h00;
		casez (instr)
		16'b1001_000?_????_????: begin
			case (instr[3:0])
			4'hC: begin ld_hit = 1'b1; ld_ptr = PTR_X; end
			4'hD: begin
				ld_hit  = 1'b1;
				ld_ptr  = PTR_X;
				ld_mode = LD_INC;
			end
			4'hE: begin
				ld_hit  = 1'b1;
				ld_ptr  = PTR_X;
				ld_mode = LD_DEC;
			end
			4'h9: begin
				ld_hit  = 1'b1;
				ld_ptr  = PTR_Y;
				ld_mode = LD_INC;
			end
			4'hA: begin
				ld_hit  = 1'b1;
				ld_ptr  = PTR_Y;
				ld_mode = LD_DEC;
			end
			4'h1: begin ld_hit = 1'b1; ld_mode = LD_INC; end
			4'h2: begin ld_hit = 1'b1; ld_mode = LD_DEC; end
			4'h0: begin ld_hit = 1'b1; ld_direct = 1'b1; end
			default: begin end
			endcase
		end
		16'b10?0_??0?_????_????: begin
			ld_hit  = 1'b1;
			ld_ptr  = instr[3] ? PTR_Y : PTR_Z;
			ld_disp = fld_q;
		end
		default: begin end
		endcase
		ptr_lo  = {2'b11, ld_ptr, 1'b0};
		ptr_hi  = {2'b11, ld_ptr, 1'b1};
		ptr_val = {regs[ptr_hi], regs[ptr_lo]};
		if (ld_direct) begin
			ld_addr = prog_next;
		end else if (ld_mode == LD_DEC) begin
			ld_addr = ptr_val - 16'h0001;
		end else begin
			ld_addr = ptr_val + {10'h000, ld_disp};
		end
		if (ld_mode == LD_DEC) begin
			ptr_new = ptr_val - 16'h0001;
		end else begin
			ptr_new = ptr_val + 16'h0001;
		end
	end

	//==========================================================
	// APB slave, zero wait states
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign pready    = psel & penable;
	assign pslverr   = pready & ~addr_ok;
	assign core_edit = apb_wr & ~run;

	always @* begin
		addr_ok     = 1'b1;
		next_prdata = 32'h0000_0000;
		case (paddr)
		`BSL_OFS_CTRL:  next_prdata[`BSL_CTRL_RUN] = run;
		`BSL_OFS_PC:    next_prdata[PC_W-1:0] = pc;
		`BSL_OFS_FLAGS: next_prdata[7:0] = flags;
		`BSL_OFS_RSEL:  next_prdata[4:0] = reg_sel;
		`BSL_OFS_RDATA: next_prdata[7:0] = regs[reg_sel];
		`BSL_OFS_STATE: next_prdata[1:0] = state;
		default:        addr_ok = 1'b0;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			run     <= `BSL_RUN_RST;
			reg_sel <= 5'h00;
		end else begin
			if (apb_setup) begin
				prdata <= next_prdata;
			end
			if (apb_wr && paddr == `BSL_OFS_CTRL) begin
				run <= pwdata[`BSL_CTRL_RUN];
			end
			if (apb_wr && paddr == `BSL_OFS_RSEL) begin
				reg_sel <= pwdata[4:0];
			end
		end
	end

	//==========================================================
	// Execution sequencer
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc        <= `BSL_PC_RST;
			flags     <= `BSL_FLAGS_RST;
			state     <= ST_EXEC;
			wait_left <= 2'h0;
			load_dst  <= 5'h00;
			data_addr <= 16'h0000;
			data_rd   <= 1'b0;
			for (i = 0; i < 32; i = i + 1) begin
				regs[i] <= 8'h00;
			end
		end else if (!run) begin
			data_rd <= 1'b0;
			if (core_edit && paddr == `BSL_OFS_PC) begin
				pc <= pwdata[PC_W-1:0];
			end
			if (core_edit && paddr == `BSL_OFS_FLAGS) begin
				flags <= pwdata[7:0];
			end
			if (core_edit && paddr == `BSL_OFS_RDATA) begin
				regs[reg_sel] <= pwdata[7:0];
			end
			if (state == ST_LOAD) begin
				regs[load_dst] <= data_rdata;
				state <= ST_EXEC;
			end else if (state == ST_WAIT && wait_left == 2'h1) begin
				state <= ST_EXEC;
			end else if (state == ST_WAIT) begin
				wait_left <= wait_left - 2'h1;
			end
		end else begin
			case (state)
			ST_WAIT: begin
				wait_left <= wait_left - 2'h1;
				if (wait_left == 2'h1) begin
					state <= ST_EXEC;
				end
			end
			ST_LOAD: begin
				regs[load_dst] <= data_rdata;
				data_rd <= 1'b0;
				state   <= ST_EXEC;
			end
			ST_EXEC: begin
				pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
				if (ld_hit) begin
					data_addr <= ld_addr;
					data_rd   <= 1'b1;
					load_dst  <= fld_d;
					state     <= ST_LOAD;
					if (ld_direct) begin
						pc <= pc + {{(PC_W-2){1'b0}}, 2'h2};
					end
					if (ld_mode != LD_PLAIN) begin
						regs[ptr_lo] <= ptr_new[7:0];
						regs[ptr_hi] <= ptr_new[15:8];
					end
				end else begin
					casez (instr)
					16'b0011_????_????_????: begin
						flags <= cmp_flags;
					end
					16'b1111_11??_????_0???: begin
						if (regs[fld_d][fld_b] == instr[9]) begin
							pc <= pc + {{(PC_W-2){1'b0}}, 2'h2} +
								{{(PC_W-1){1'b0}}, skip_two};
							wait_left <= skip_cyc;
							state     <= ST_WAIT;
						end
					end
					16'b1001_10?1_????_????: begin
						if (io_bits[{fld_io, fld_b}] == instr[9]) begin
							pc <= pc + {{(PC_W-2){1'b0}}, 2'h2} +
								{{(PC_W-1){1'b0}}, skip_two};
							wait_left <= skip_cyc;
							state     <= ST_WAIT;
						end
					end
					16'b1111_0???_????_????: begin
						// Bit 10 low selects the set variant
						if (flag_cond == ~instr[10]) begin
							pc <= br_target;
							wait_left <= `BSL_CYC_TAKEN;
							state     <= ST_WAIT;
						end
					end
					16'b0010_11??_????_????: begin
						regs[fld_d] <= regs[fld_r];
					end
					16'b0000_0001_????_????: begin
						regs[{instr[7:4], 1'b0}] <= regs[{instr[3:0], 1'b0}];
						regs[{instr[7:4], 1'b1}] <=
							regs[{instr[3:0], 1'b1}];
					end
					16'b1110_????_????_????: begin
						regs[fld_dh] <= fld_k;
					end
					default: begin end
					endcase
				end
			end
			default: state <= ST_EXEC;
			endcase
		end
	end

endmodule

// File: verif/bsl_core_checker.sv
// Port assertions for the branch, skip and load core.
// Assumes the run bit is bit 0 of the register at offset 0x00.
`timescale 1ns/1ns
module bsl_core_checker #(
	parameter PC_W = 16
) (
	input logic            sys_clk,
	input logic            rst_n,
	input logic            psel,
	input logic            penable,
	input logic            pwrite,
	input logic [7:0]      paddr,
	input logic [31:0]     pwdata,
	input logic [PC_W-1:0] prog_addr,
	input logic [15:0]     prog_data,
	input logic [15:0]     prog_next,
	input logic [15:0]     data_addr,
	input logic            data_rd
);
	logic run_m;
	wire  load_direct_op = prog_data[15:9] == 7'h48 && prog_data[3:0] == 4'h0;
	wire  ldx = prog_data[15:9] == 7'h48 ||
		(prog_data[15:14] == 2'h2 && !prog_data[12] && !prog_data[9]);
	wire  skp = prog_data[15:10] == 6'h3F || prog_data[15:8] == 8'h99 ||
		prog_data[15:8] == 8'h9B;
	wire  one = prog_data[15:12] == 4'h3 || prog_data[15:12] == 4'hE ||
		prog_data[15:10] == 6'h0B || prog_data[15:8] == 8'h01;
	// ========
	// Run bit mirror
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			run_m <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h00)
			run_m <= pwdata[0];
	// ========
	// Assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_read_pulse: assert property (
		data_rd |=> !data_rd)
		else $error("load strobe longer than one cycle");
	a_read_cause: assert property (
		$rose(data_rd) |-> $past(ldx))
		else $error("load strobe without a load opcode");
	a_direct_addr: assert property (
		$rose(data_rd) && $past(load_direct_op) |-> data_addr == $past(prog_next))
		else $error("direct load address wrong");
	a_direct_pc: assert property (
		$rose(data_rd) && $past(load_direct_op) |->
		prog_addr == $past(prog_addr) + 2'h2)
		else $error("direct load did not step two words");
	a_indirect_pc: assert property (
		$rose(data_rd) && !$past(load_direct_op) |->
		prog_addr == $past(prog_addr) + 1'b1)
		else $error("indirect load did not step one word");
	a_branch_wait: assert property (
		run_m && $past(run_m) && prog_addr != $past(prog_addr) &&
		prog_addr != $past(prog_addr) + 1'b1 |=> $stable(prog_addr))
		else $error("jump without a wait cycle");
	a_skip_two: assert property (
		run_m && $past(run_m) && $past(skp) &&
		prog_addr == $past(prog_addr) + 2'h3 |=> $stable(prog_addr) [*2])
		else $error("two-word skip not three cycles");
	a_one_cycle: assert property (
		run_m && $past(run_m) && !data_rd && one &&
		prog_addr == $past(prog_addr) + 1'b1 |=>
		prog_addr == $past(prog_addr) + 1'b1)
		else $error("single cycle op stalled");
endmodule

bind bsl_core bsl_core_checker #(.PC_W(PC_W)) bsl_core_checker_i (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prog_addr(prog_addr),
	.prog_data(prog_data),
	.prog_next(prog_next),
	.data_addr(data_addr),
	.data_rd(data_rd)
);

// File: verif/bsl_mem_model.sv
// Program memory and data space seen by the core.
// Assumes the bench fills rom while the core is halted.
`timescale 1ns/1ns
module bsl_mem_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] prog_addr,
	output wire logic [15:0] prog_data,
	output wire logic [15:0] prog_next,
	input  wire logic [15:0] data_addr,
	input  wire logic        data_rd,
	output wire logic [7:0]  data_rdata
);
	logic [15:0] rom [0:255];
	logic [7:0]  last = 8'h00;
	assign prog_data = rom[prog_addr[7:0]];
	assign prog_next = rom[prog_addr[7:0] + 8'h01];
	// Idle bus shows the inverse of the last byte
	assign data_rdata = data_rd ?
		data_addr[7:0] ^ data_addr[15:8] ^ 8'h3C : ~last;
	always @(posedge sys_clk)
		last <= data_rdata;
endmodule

// File: verif/test_branch_skip_load_exec.sv
// Self-checking bench for the branch, skip and load core.
// Assumes the core, checker and memory model compile first.
`timescale 1ns/1ns
module test_branch_skip_load_exec;
	logic         sys_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0;
	logic [255:0] io_bits = 256'h0;
	wire  [31:0]  prdata;
	wire          pready;
	wire          pslverr;
	wire  [15:0]  prog_addr;
	wire  [15:0]  prog_data;
	wire  [15:0]  prog_next;
	wire  [15:0]  data_addr;
	wire          data_rd;
	wire  [7:0]   data_rdata;
	logic [31:0]  rd;
	logic         err;
	int           n_mismatch = 0;
	int           checked = 0;
	int           cyc = 0;
	always #20 sys_clk = ~sys_clk;
	bsl_core bsl_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
		.prog_next(prog_next), .io_bits(io_bits), .data_addr(data_addr),
		.data_rd(data_rd), .data_rdata(data_rdata));
	bsl_mem_model bsl_mem_model_i (.sys_clk(sys_clk),
		.prog_addr(prog_addr), .prog_data(prog_data),
		.prog_next(prog_next), .data_addr(data_addr),
		.data_rd(data_rd), .data_rdata(data_rdata));
	// ========
	// Bus and compare tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic reg_wr(input logic [4:0] i, input logic [7:0] v);
		apb(1'b1, 8'h0C, {27'h0, i});
		apb(1'b1, 8'h10, {24'h0, v});
	endtask
	task automatic expect_reg(input logic [4:0] i, input logic [7:0] v);
		apb(1'b1, 8'h0C, {27'h0, i});
		apb(1'b0, 8'h10, 32'h0);
		chk($sformatf("r%0d", i), {24'h0, v}, rd);
	endtask
	task automatic run(input logic [15:0] p[$]);
		foreach (bsl_mem_model_i.rom[i])
			bsl_mem_model_i.rom[i] = 16'h0000;
		foreach (p[i])
			bsl_mem_model_i.rom[i] = p[i];
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		repeat (60) @(posedge sys_clk);
		apb(1'b1, 8'h00, 32'h0);
	endtask
	// ========
	// Scenarios
	task automatic t_reset;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, 8'h08, 32'h0);
		chk("flags", 32'h0, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask
	task automatic t_flow;
		run('{16'hE005, 16'h3006, 16'h2E10, 16'hF008, 16'hEA1A, 16'hFF00,
			16'h9130, 16'h1234, 16'hE727, 16'hF409, 16'hEA1A, 16'hF40C,
			16'hE141, 16'h990A, 16'hE252, 16'h01C8, 16'hF00D, 16'hEA1A,
			16'hF40E, 16'hEA1A, 16'hF00F, 16'hE363});
		apb(1'b0, 8'h08, 32'h0);
		chk("flags", 32'h25, rd);
		expect_reg(5'h10, 8'h05);
		expect_reg(5'h01, 8'h05);
		expect_reg(5'h11, 8'h00);
		expect_reg(5'h12, 8'h77);
		expect_reg(5'h13, 8'h00);
		expect_reg(5'h14, 8'h11);
		expect_reg(5'h15, 8'h00);
		expect_reg(5'h16, 8'h33);
		expect_reg(5'h18, 8'h05);
	endtask
	task automatic t_load;
		reg_wr(5'h1A, 8'h10);
		reg_wr(5'h1B, 8'h01);
		reg_wr(5'h1C, 8'h40);
		reg_wr(5'h1D, 8'h00);
		run('{16'h902D, 16'h903D, 16'h906E, 16'h9040, 16'h0234,
			16'h805D});
		expect_reg(5'h02, 8'h2D);
		expect_reg(5'h03, 8'h2C);
		expect_reg(5'h06, 8'h2C);
		expect_reg(5'h1A, 8'h11);
		expect_reg(5'h04, 8'h0A);
		expect_reg(5'h05, 8'h79);
		expect_reg(5'h1C, 8'h40);
		apb(1'b0, 8'h08, 32'h0);
		chk("flags", 32'h25, rd);
	endtask
	// ========
	// Sequence, watchdog and verdict
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_flow;
		t_load;
		final_report;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			final_report;
		end
	end
endmodule
